// *** pfs_pkg.sv ***
// package of constants and types for the power fault supervisor
package pfs_pkg;
   localparam int TEL_W = 12;
   localparam int ADDR_W = 4;
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_OT_FAULT = 4'h1;
   localparam logic [3:0] REG_OT_WARN = 4'h2;
   localparam logic [3:0] REG_INPUT_OVERVOLT_FAULT = 4'h3;
   localparam logic [3:0] REG_INPUT_OVERVOLT_WARNING = 4'h4;
   localparam logic [3:0] REG_VIN_ON = 4'h5;
   localparam logic [3:0] REG_INPUT_UNDERVOLT_FAULT = 4'h6;
   localparam logic [3:0] REG_INPUT_UNDERVOLT_WARNING = 4'h7;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_MASK = 4'h9;
   localparam logic [3:0] REG_STATE = 4'ha;
   localparam logic [3:0] REG_TEMP_A = 4'hb;
   localparam logic [3:0] REG_TEMP_B = 4'hc;
   localparam logic [3:0] REG_VIN = 4'hd;
   // status bit positions
   localparam int ST_OTF_A = 0;
   localparam int ST_OTF_B = 1;
   localparam int ST_OTW_A = 2;
   localparam int ST_OTW_B = 3;
   localparam int ST_SF_A = 4;
   localparam int ST_SF_B = 5;
   localparam int ST_NR_A = 6;
   localparam int ST_NR_B = 7;
   localparam int ST_OVF = 8;
   localparam int ST_OVW = 9;
   localparam int ST_UVF = 10;
   localparam int ST_UVW = 11;
   localparam int ST_W = 12;
   // ctrl fields: [1:0] channel enables, [2] ot resp ignore, [3] stage resp ignore,
   // [4] ov resp ignore
   localparam int CT_OT_IGN = 2;
   localparam int CT_SF_IGN = 3;
   localparam int CT_OV_IGN = 4;
   localparam int CT_W = 5;
   // reset limits in telemetry codes (degC for temp, 10 mV units for vin)
   localparam logic [11:0] RST_OT_FAULT = 12'h07d;
   localparam logic [11:0] RST_OT_WARN = 12'h069;
   localparam logic [11:0] RST_INPUT_OVERVOLT_FAULT = 12'h76c;
   localparam logic [11:0] RST_INPUT_OVERVOLT_WARNING = 12'h708;
   localparam logic [11:0] RST_VIN_ON = 12'h1a9;
   localparam logic [11:0] RST_INPUT_UNDERVOLT_FAULT = 12'h190;
   localparam logic [11:0] RST_INPUT_UNDERVOLT_WARNING = 12'h190;
   localparam logic [11:0] RST_MASK = 12'h000;
   typedef enum logic [1:0] {
      PFS_CH_OFF = 2'b01,
      PFS_CH_RUN = 2'b10
   } pfs_ch_t;
endpackage

// *** pfs_supervisor.sv ***
// protection supervisor: limits, status, alert and pwm tristate per channel
// Behaviour
// [RQ1] digitize per-channel temperature sense input
// [RQ2] over-temperature fault above fault limit
// [RQ3] over-temperature warning above warning limit
// [RQ4] warning sets status, alert unless masked
// [RQ5] fault tristates rail unless response ignore
// [RQ6] stage fault when line above threshold
// [RQ7] stage fault tristates channel, sets status
// [RQ8] not-ready while line low, blocks start
// [RQ9] no status at initial power-on not-ready
// [RQ10] start immediately when line released, enabled
// [RQ11] not-ready tristates, flags, always hysteretic
// [RQ12] input overvoltage fault above limit
// [RQ13] input overvoltage warning above limit
// [RQ14] overvoltage fault tristates both channels
// [RQ15] ignore enable below turn-on threshold
// [RQ16] mask undervoltage until turn-on first exceeded
// [RQ17] undervoltage fault stops conversion
// [RQ18] undervoltage warning below warning limit
// [RQ19] undervoltage fault clears above turn-on
// [RQ20] undervoltage armed only while channel enabled
// [RQ21] toggling both enables clears undervoltage fault
// [RQ22] host enables after input passes turn-on
// [RQ23] status sticky until cleared; alert follows
`timescale 1ns/1ps
module pfs_supervisor
   import pfs_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic [ADDR_W-1:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [TEL_W-1:0] temp_sense_a_i,
   input wire logic [TEL_W-1:0] temp_sense_b_i,
   input wire logic stage_fault_a_i,
   input wire logic stage_fault_b_i,
   input wire logic stage_low_a_i,
   input wire logic stage_low_b_i,
   input wire logic [TEL_W-1:0] vin_code_i,
   output logic [1:0] pwm_tristate_o,
   output logic [1:0] converting_o,
   output logic alert_o
);
   // pins are synchronised by two stages before use
   typedef struct packed {
      logic [1:0][TEL_W-1:0] t1, t2;
      logic [1:0] sf1, sf2, lo1, lo2;
      logic [TEL_W-1:0] v1, v2;
      logic [CT_W-1:0] ctrl;
      logic [TEL_W-1:0] ot_fault, ot_warn, ovf, ovw, von, uvf, uvw;
      logic [ST_W-1:0] status, mask;
      pfs_ch_t [1:0] ch;
      logic [1:0] tri_st;
      logic von_seen;
      logic uv_act;
      logic [1:0] en_q;
      logic [1:0] ever_run;
      logic ack;
      logic [31:0] rdata;
   } pfs_state_t;

   pfs_state_t s, next_s;

   function automatic logic [31:0] pfs_rd(input pfs_state_t q, input logic [3:0] a);
      logic [31:0] r;
      r = '0;
      unique case (a)
         REG_CTRL: r[CT_W-1:0] = q.ctrl;
         REG_OT_FAULT: r[TEL_W-1:0] = q.ot_fault;
         REG_OT_WARN: r[TEL_W-1:0] = q.ot_warn;
         REG_INPUT_OVERVOLT_FAULT: r[TEL_W-1:0] = q.ovf;
         REG_INPUT_OVERVOLT_WARNING: r[TEL_W-1:0] = q.ovw;
         REG_VIN_ON: r[TEL_W-1:0] = q.von;
         REG_INPUT_UNDERVOLT_FAULT: r[TEL_W-1:0] = q.uvf;
         REG_INPUT_UNDERVOLT_WARNING: r[TEL_W-1:0] = q.uvw;
         REG_STATUS: r[ST_W-1:0] = q.status;
         REG_MASK: r[ST_W-1:0] = q.mask;
         REG_STATE: r[3:0] = {q.tri_st, q.ch[1] == PFS_CH_RUN, q.ch[0] == PFS_CH_RUN};
         REG_TEMP_A: r[TEL_W-1:0] = q.t2[0];
         REG_TEMP_B: r[TEL_W-1:0] = q.t2[1];
         REG_VIN: r[TEL_W-1:0] = q.v2;
         default: r = '0;
      endcase
      return r;
   endfunction

   logic [ST_W-1:0] ev;
   logic [1:0] kill;
   logic wr, rd;

   always_comb begin
      next_s = s;
      ev = '0;
      kill = '0;
      // a write commits only at the edge where waitrequest is already low
      wr = avs_write_i && s.ack;
      rd = avs_read_i && !s.ack;
      next_s.t1 = {temp_sense_b_i, temp_sense_a_i};
      next_s.t2 = s.t1; // [RQ1]
      next_s.sf1 = {stage_fault_b_i, stage_fault_a_i};
      next_s.sf2 = s.sf1;
      next_s.lo1 = {stage_low_b_i, stage_low_a_i};
      next_s.lo2 = s.lo1;
      next_s.v1 = vin_code_i;
      next_s.v2 = s.v1;
      next_s.en_q = s.ctrl[1:0];
      for (int c = 0; c < 2; c++) begin
         if (s.t2[c] > s.ot_fault) begin // [RQ2]
            ev[ST_OTF_A + c] = 1'b1;
            if (!s.ctrl[CT_OT_IGN]) kill[c] = 1'b1; // [RQ5]
         end
         if (s.t2[c] > s.ot_warn) ev[ST_OTW_A + c] = 1'b1; // [RQ3] [RQ4]
         if (s.sf2[c]) begin // [RQ6]
            ev[ST_SF_A + c] = 1'b1;
            if (!s.ctrl[CT_SF_IGN]) kill[c] = 1'b1; // [RQ7]
         end
         // not-ready flags only once the channel has run; blocks start regardless
         if (s.lo2[c] && s.ever_run[c]) ev[ST_NR_A + c] = 1'b1; // [RQ9] [RQ11]
         if (s.lo2[c]) kill[c] = 1'b1; // [RQ8] [RQ11]
      end
      if (s.v2 > s.ovf) begin // [RQ12]
         ev[ST_OVF] = 1'b1;
         if (!s.ctrl[CT_OV_IGN]) kill = 2'b11; // [RQ14]
      end
      if (s.v2 > s.ovw) ev[ST_OVW] = 1'b1; // [RQ13]
      if (s.v2 > s.von) next_s.von_seen = 1'b1; // [RQ16]
      if (s.von_seen && s.v2 < s.uvw) ev[ST_UVW] = 1'b1; // [RQ18]
      if (s.von_seen && (s.ctrl[1:0] != 2'b00) && s.v2 < s.uvf) begin // [RQ17] [RQ20]
         ev[ST_UVF] = 1'b1;
         next_s.uv_act = 1'b1;
      end else if (s.uv_act && s.v2 > s.von) begin
         next_s.uv_act = 1'b0; // [RQ19]
      end
      // both enables toggled together above the fault limit clears it
      if (s.uv_act && s.en_q == 2'b00 && s.ctrl[1:0] == 2'b11 && s.v2 > s.uvf)
         next_s.uv_act = 1'b0; // [RQ21]
      for (int c = 0; c < 2; c++) begin
         unique case (s.ch[c])
            PFS_CH_OFF: begin
               next_s.tri_st[c] = 1'b1;
               // enable honoured only above turn-on and with no blocking fault
               if (s.ctrl[c] && !kill[c] && !s.uv_act && !ev[ST_UVF] &&
                  s.v2 > s.von) begin // [RQ15] [RQ10]
                  next_s.ch[c] = PFS_CH_RUN;
                  next_s.tri_st[c] = 1'b0;
                  next_s.ever_run[c] = 1'b1;
               end
            end
            PFS_CH_RUN: begin
               // a later drop below turn-on alone does not stop conversion
               if (!s.ctrl[c] || kill[c] || (ev[ST_UVF])) begin // [RQ17]
                  next_s.ch[c] = PFS_CH_OFF;
                  next_s.tri_st[c] = 1'b1;
               end
            end
         endcase
      end
      next_s.status = s.status | ev; // [RQ23]
      next_s.ack = (avs_read_i || avs_write_i) && !s.ack;
      if (rd) next_s.rdata = pfs_rd(s, avs_address_i);
      if (wr) begin
         unique case (avs_address_i)
            REG_CTRL: next_s.ctrl = avs_writedata_i[CT_W-1:0];
            REG_OT_FAULT: next_s.ot_fault = avs_writedata_i[TEL_W-1:0];
            REG_OT_WARN: next_s.ot_warn = avs_writedata_i[TEL_W-1:0];
            REG_INPUT_OVERVOLT_FAULT: next_s.ovf = avs_writedata_i[TEL_W-1:0];
            REG_INPUT_OVERVOLT_WARNING: next_s.ovw = avs_writedata_i[TEL_W-1:0];
            REG_VIN_ON: next_s.von = avs_writedata_i[TEL_W-1:0];
            REG_INPUT_UNDERVOLT_FAULT: next_s.uvf = avs_writedata_i[TEL_W-1:0];
            REG_INPUT_UNDERVOLT_WARNING: next_s.uvw = avs_writedata_i[TEL_W-1:0];
            // write one to clear; a new event in the same cycle wins
            REG_STATUS: next_s.status = (s.status & ~avs_writedata_i[ST_W-1:0]) | ev; // [RQ23]
            REG_MASK: next_s.mask = avs_writedata_i[ST_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s <= '0;
         s.ot_fault <= RST_OT_FAULT;
         s.ot_warn <= RST_OT_WARN;
         s.ovf <= RST_INPUT_OVERVOLT_FAULT;
         s.ovw <= RST_INPUT_OVERVOLT_WARNING;
         s.von <= RST_VIN_ON;
         s.uvf <= RST_INPUT_UNDERVOLT_FAULT;
         s.uvw <= RST_INPUT_UNDERVOLT_WARNING;
         s.mask <= RST_MASK;
         s.ch <= {PFS_CH_OFF, PFS_CH_OFF};
         s.tri_st <= 2'b11;
      end else begin
         s <= next_s;
      end
   end

   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s.ack;
   assign avs_readdata_o = s.rdata;
   assign pwm_tristate_o = s.tri_st;
   assign converting_o = {s.ch[1] == PFS_CH_RUN, s.ch[0] == PFS_CH_RUN};
   assign alert_o = |(s.status & ~s.mask); // [RQ4] [RQ23]

   // telemetry path
   chk_temp_sync: assert property ( // [RQ1]
      @(posedge core_clk_i) disable iff (reset_i)
      1'b1 |=> s.t2 == $past(s.t1))
      else $error("temperature telemetry not taken from sync stage");

   // over-temperature
   chk_otf_flag_a: assert property ( // [RQ2]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.t2[0] > s.ot_fault) |=> s.status[ST_OTF_A])
      else $error("ot fault a not flagged");

   chk_otf_flag_b: assert property ( // [RQ2]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.t2[1] > s.ot_fault) |=> s.status[ST_OTF_B])
      else $error("ot fault b not flagged");

   chk_otw_flag_a: assert property ( // [RQ3]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.t2[0] > s.ot_warn) |=> s.status[ST_OTW_A])
      else $error("ot warning a not flagged");

   chk_otw_status: assert property ( // [RQ3]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.t2[1] > s.ot_warn) |=> s.status[ST_OTW_B])
      else $error("ot warning b not flagged");

   chk_otw_alert: assert property ( // [RQ4]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.status[ST_OTW_A] && !s.mask[ST_OTW_A]) |-> alert_o)
      else $error("unmasked ot warning without alert");

   chk_otf_tristate: assert property ( // [RQ5]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.t2[0] > s.ot_fault && !s.ctrl[CT_OT_IGN]) |=> s.tri_st[0])
      else $error("ot fault did not tristate channel a");

   chk_otf_tristate_b: assert property ( // [RQ5]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.t2[1] > s.ot_fault && !s.ctrl[CT_OT_IGN]) |=> s.tri_st[1])
      else $error("ot fault did not tristate channel b");

   // power-stage fault and not-ready
   chk_sf_flag_a: assert property ( // [RQ6]
      @(posedge core_clk_i) disable iff (reset_i)
      s.sf2[0] |=> s.status[ST_SF_A])
      else $error("stage fault a not flagged");

   chk_sf_flag_b: assert property ( // [RQ6]
      @(posedge core_clk_i) disable iff (reset_i)
      s.sf2[1] |=> s.status[ST_SF_B])
      else $error("stage fault b not flagged");

   chk_sf_off_a: assert property ( // [RQ7]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.sf2[0] && !s.ctrl[CT_SF_IGN]) |=> s.tri_st[0])
      else $error("stage fault did not tristate channel a");

   chk_sf_off_b: assert property ( // [RQ7]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.sf2[1] && !s.ctrl[CT_SF_IGN]) |=> s.tri_st[1])
      else $error("stage fault did not tristate channel b");

   chk_not_ready_block: assert property ( // [RQ8]
      @(posedge core_clk_i) disable iff (reset_i)
      s.lo2[0] |=> s.ch[0] == PFS_CH_OFF)
      else $error("channel a started while stage not ready");

   chk_not_ready_b: assert property ( // [RQ8]
      @(posedge core_clk_i) disable iff (reset_i)
      s.lo2[1] |=> s.ch[1] == PFS_CH_OFF)
      else $error("channel b started while stage not ready");

   chk_silent_power_on: assert property ( // [RQ9]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.lo2[0] && !s.ever_run[0]) |-> !ev[ST_NR_A])
      else $error("not-ready flagged at initial power-on");

   chk_release_start: assert property ( // [RQ10]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.ch[0] == PFS_CH_OFF && s.ctrl[0] && !kill[0] && !s.uv_act && !ev[ST_UVF] &&
      s.v2 > s.von) |=> s.ch[0] == PFS_CH_RUN)
      else $error("start delayed after release");

   chk_nr_flag_b: assert property ( // [RQ11]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.lo2[1] && s.ever_run[1]) |=> s.status[ST_NR_B] && s.tri_st[1])
      else $error("not-ready b not flagged or not tristated");

   // input overvoltage
   chk_ovf_flag: assert property ( // [RQ12]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.v2 > s.ovf) |=> s.status[ST_OVF])
      else $error("input ov fault not flagged");

   chk_ovw_flag: assert property ( // [RQ13]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.v2 > s.ovw) |=> s.status[ST_OVW])
      else $error("input ov warning not flagged");

   chk_ovf_both_off: assert property ( // [RQ14]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.v2 > s.ovf && !s.ctrl[CT_OV_IGN]) |=> s.tri_st == 2'b11)
      else $error("ov fault did not tristate both channels");

   // turn-on gating and undervoltage
   chk_vin_on_gate: assert property ( // [RQ15]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.ch[1] == PFS_CH_OFF && s.v2 <= s.von) |=> s.ch[1] == PFS_CH_OFF)
      else $error("enable honoured below turn-on");

   chk_run_holds: assert property ( // [RQ15]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.ch[0] == PFS_CH_RUN && s.ctrl[0] && !kill[0] && !ev[ST_UVF])
      |=> s.ch[0] == PFS_CH_RUN)
      else $error("conversion stopped without a cause");

   chk_uv_masked: assert property ( // [RQ16]
      @(posedge core_clk_i) disable iff (reset_i)
      !s.von_seen |-> !ev[ST_UVF] && !ev[ST_UVW])
      else $error("undervoltage flagged before turn-on seen");

   chk_uvf_stop: assert property ( // [RQ17]
      @(posedge core_clk_i) disable iff (reset_i)
      ev[ST_UVF] |=> s.ch[0] == PFS_CH_OFF && s.ch[1] == PFS_CH_OFF)
      else $error("undervoltage fault did not stop conversion");

   chk_uvw_flag: assert property ( // [RQ18]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.von_seen && s.v2 < s.uvw) |=> s.status[ST_UVW])
      else $error("undervoltage warning not flagged");

   chk_uv_clear: assert property ( // [RQ19]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.uv_act && !ev[ST_UVF] && s.v2 > s.von) |=> !s.uv_act)
      else $error("undervoltage fault not cleared above turn-on");

   chk_uv_armed: assert property ( // [RQ20]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.ctrl[1:0] == 2'b00) |-> !ev[ST_UVF])
      else $error("undervoltage fault armed with both channels off");

   chk_uv_toggle: assert property ( // [RQ21]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.uv_act && s.en_q == 2'b00 && s.ctrl[1:0] == 2'b11 && s.v2 > s.uvf)
      |=> !s.uv_act)
      else $error("joint enable toggle did not clear undervoltage");

   // status, alert and bus
   chk_alert_follows: assert property ( // [RQ23]
      @(posedge core_clk_i) disable iff (reset_i)
      (|(s.status & ~s.mask)) == alert_o)
      else $error("alert does not follow unmasked status");

   chk_sticky_status: assert property ( // [RQ23]
      @(posedge core_clk_i) disable iff (reset_i)
      (s.status[ST_SF_A] && !(wr && avs_address_i == REG_STATUS)) |=> s.status[ST_SF_A])
      else $error("status bit dropped without clear");

   chk_wait_first: assert property (
      @(posedge core_clk_i) disable iff (reset_i)
      ((avs_read_i || avs_write_i) && !s.ack) |-> avs_waitrequest_o)
      else $error("request answered without a wait state");

   cov_ot_fault: cover property (@(posedge core_clk_i) s.status[ST_OTF_A]);

   cov_uv_fault: cover property (@(posedge core_clk_i) s.uv_act);

   cov_run: cover property (@(posedge core_clk_i) converting_o == 2'b11);

   cov_not_ready: cover property (@(posedge core_clk_i) s.status[ST_NR_A]);

   cov_masked_fault: cover property (@(posedge core_clk_i) s.status[ST_OVF] && !alert_o);
endmodule

// *** pfs_stage_model.sv ***
// model of the power stages that share each channel's sense line
`timescale 1ns/1ps
module pfs_stage_model
   import pfs_pkg::*;
(
   input wire logic [TEL_W-1:0] die_a_i,
   input wire logic [TEL_W-1:0] die_b_i,
   input wire logic [1:0] fault_i,
   input wire logic [1:0] not_ready_i,
   output logic [TEL_W-1:0] temp_sense_a_o,
   output logic [TEL_W-1:0] temp_sense_b_o,
   output logic [1:0] stage_fault_o,
   output logic [1:0] stage_low_o
);
   // a line held low reads as zero temperature
   assign temp_sense_a_o = not_ready_i[0] ? '0 : die_a_i;
   assign temp_sense_b_o = not_ready_i[1] ? '0 : die_b_i;
   assign stage_fault_o = fault_i & ~not_ready_i;
   assign stage_low_o = not_ready_i;
endmodule

// *** tb.sv ***
// testbench for the power fault supervisor
`timescale 1ns/1ps
module tb;
   import pfs_pkg::*;
   typedef struct {
      logic [11:0] ta, tb, vin;
      logic [1:0] flt;
      logic [11:0] st;
      logic [3:0] state;
   } pfs_row_t;
   logic clk = 0;
   logic rst = 1;
   logic [3:0] adr = '0;
   logic rd = 0;
   logic wr = 0;
   logic [31:0] wd = '0;
   logic [31:0] rdata;
   logic [31:0] q;
   logic wreq;
   logic alert;
   logic [1:0] tri_st, conv, sfl, slow;
   logic [11:0] tmp_a = 12'h019;
   logic [11:0] tmp_b = 12'h019;
   logic [11:0] vin = 12'h4b0;
   logic [11:0] sa, sb;
   logic [1:0] flt = '0;
   logic [1:0] nrdy = 2'b01;
   int error_cnt = 0;
   int n_checks = 0;
   pfs_row_t rows [7] = '{
      '{12'h07e, 12'h019, 12'h4b0, 2'b00, 12'h005, 4'h6},
      '{12'h019, 12'h07d, 12'h4b0, 2'b00, 12'h008, 4'h3},
      '{12'h019, 12'h019, 12'h4b0, 2'b01, 12'h010, 4'h6},
      '{12'h019, 12'h019, 12'h4b0, 2'b10, 12'h020, 4'h9},
      '{12'h019, 12'h019, 12'h709, 2'b00, 12'h200, 4'h3},
      '{12'h019, 12'h019, 12'h76d, 2'b00, 12'h300, 4'hc},
      '{12'h019, 12'h019, 12'h186, 2'b00, 12'hc00, 4'hc}};
   always #10 clk = ~clk;
   pfs_stage_model stages (.die_a_i(tmp_a), .die_b_i(tmp_b), .fault_i(flt),
      .not_ready_i(nrdy), .temp_sense_a_o(sa), .temp_sense_b_o(sb),
      .stage_fault_o(sfl), .stage_low_o(slow));
   pfs_supervisor uut (.core_clk_i(clk), .reset_i(rst), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
      .temp_sense_a_i(sa), .temp_sense_b_i(sb), .stage_fault_a_i(sfl[0]),
      .stage_fault_b_i(sfl[1]), .stage_low_a_i(slow[0]), .stage_low_b_i(slow[1]),
      .vin_code_i(vin), .pwm_tristate_o(tri_st), .converting_o(conv),
      .alert_o(alert));
   task automatic give_verdict;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // request held until waitrequest is seen low, then released
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 20);
      if (wreq !== 1'b0) begin
         error_cnt++;
         give_verdict();
      end
      q = rdata;
      rd <= 0;
      wr <= 0;
      // one idle edge: lets the write settle and keeps back-to-back calls apart
      @(posedge clk);
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input string what);
      bus(0, a, '0);
      chk(q, exp, what);
   endtask
   // two sync stages, one acting edge, plus margin
   task automatic settle;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      settle();
      rdchk(REG_STATUS, 0, "status reset");
      rdchk(REG_OT_FAULT, RST_OT_FAULT, "limit reset");
      rdchk(4'he, 0, "unmapped");
      rdchk(REG_STATE, 32'hc, "state reset");
      bus(1, REG_CTRL, 32'h3);
      settle();
      rdchk(REG_STATE, 32'h6, "blocked start");
      rdchk(REG_STATUS, 0, "silent power-on");
      nrdy <= 2'b00;
      settle();
      rdchk(REG_STATE, 32'h3, "start on release");
      nrdy <= 2'b01;
      settle();
      rdchk(REG_STATUS, 32'h040, "not ready");
      rdchk(REG_STATE, 32'h6, "not ready off");
      nrdy <= 2'b00;
      settle();
      rdchk(REG_STATE, 32'h3, "hysteretic restart");
      bus(1, REG_STATUS, 32'hfff);
      foreach (rows[i]) begin
         tmp_a <= rows[i].ta;
         tmp_b <= rows[i].tb;
         vin <= rows[i].vin;
         flt <= rows[i].flt;
         settle();
         rdchk(REG_STATUS, rows[i].st, "row status");
         rdchk(REG_STATE, rows[i].state, "row state");
         chk(alert, 1, "row alert");
         tmp_a <= 12'h019;
         tmp_b <= 12'h019;
         vin <= 12'h4b0;
         flt <= 2'b00;
         settle();
         bus(1, REG_CTRL, 0);
         bus(1, REG_STATUS, 32'hfff);
         chk(alert, 0, "alert cleared");
         bus(1, REG_CTRL, 32'h3);
      end
      bus(1, REG_CTRL, 32'h1f);
      bus(1, REG_MASK, 32'h315);
      tmp_a <= 12'h07e;
      flt <= 2'b01;
      vin <= 12'h76d;
      settle();
      rdchk(REG_STATE, 32'h3, "ignore response");
      chk(alert, 0, "masked alert");
      tmp_a <= 12'h019;
      flt <= 2'b00;
      vin <= 12'h4b0;
      settle();
      rdchk(REG_STATUS, 32'h315, "sticky status");
      bus(1, REG_MASK, 0);
      chk(alert, 1, "unmasked alert");
      rst <= 1;
      vin <= 12'h12c;
      repeat (16) @(posedge clk);
      rst <= 0;
      settle();
      rdchk(REG_STATUS, 0, "uv masked");
      vin <= 12'h1a4;
      bus(1, REG_CTRL, 32'h3);
      settle();
      rdchk(REG_STATE, 32'hc, "enable below on");
      vin <= 12'h4b0;
      bus(1, REG_CTRL, 0);
      bus(1, REG_CTRL, 32'h3);
      settle();
      vin <= 12'h19a;
      settle();
      rdchk(REG_STATE, 32'h3, "dip above uv");
      rdchk(REG_STATUS, 0, "dip no status");
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      give_verdict();
   end
endmodule
